// >>> inc/nvm_access_pkg.sv
// Purpose: shared constants and types for the non-volatile access block
// Assumes: 200 MHz system clock
// Notes: times are kept in their printed unit, cycle counts derive from them
package nvm_access_pkg;

    localparam int CLOCK_MHZ = 200;
    localparam int SECTOR_BYTES = 32768;
    localparam int FLASH_SECTORS = 8;
    localparam int PAGEWORD_BYTES = 16;
    localparam int EE_SEG_BYTES = 64;
    localparam int EE_SEGMENTS = 64;
    localparam int ADDR_W = 24;
    localparam int LEN_W = 16;
    localparam int PROG_TIME_MS = 1;
    localparam int ERASE_TIME_MS = 100;
    localparam int unsigned PROG_CYCLES = PROG_TIME_MS * 1000 * CLOCK_MHZ;
    localparam int unsigned ERASE_CYCLES = ERASE_TIME_MS * 1000 * 1000 / 1000 * CLOCK_MHZ;
    localparam logic [7:0] FLASH_BLANK = 8'hFF;
    localparam logic [7:0] EE_BLANK = 8'h00;

    typedef enum logic [3:0] {
        OP_FLASH_READ,
        OP_FLASH_PROGRAM,
        OP_FLASH_ERASE,
        OP_EXT_POWER_OFF,
        OP_EXT_POWER_ON,
        OP_EE_INIT,
        OP_EE_WRITE,
        OP_EE_READ,
        OP_EE_ERASE
    } op_type;

    typedef enum logic [2:0] {
        ST_OK,
        ST_ALIGN,
        ST_RANGE,
        ST_OVERRUN,
        ST_PROTECTED,
        ST_READ_ERROR
    } status_type;

    typedef enum logic [1:0] {
        EXT_INTERNAL,
        EXT_POWER_CTL,
        EXT_OTHER,
        EXT_CUSTOM
    } ext_kind_type;

endpackage

// >>> hdl/flash_eeprom_access_control.sv
// Purpose: command-driven access to on-chip flash and eeprom arrays
// Assumes: requester on the same clock; one command at a time
// Notes: arrays are not reset; erase before first use
//
// How it works
// - flash program only clears bits
// - program needs 16-byte aligned start and length
// - read of damaged pageword raises error interrupt
// - sector erase sets whole sector to ones
// - program completion waits the programming time
// - power commands only affect supported external type
// - eeprom blank is zero, writes only set
// - 64-byte segments, init reports count and size
// - last eeprom segment refuses write and erase
// - eeprom write overrunning segment errors, writes nothing
// - eeprom read overrunning segment errors, reads nothing
// - eeprom erase clears exactly one segment
`timescale 1ns/1ps

module flash_eeprom_access_control #(
    parameter int FLASH_SECTORS = nvm_access_pkg::FLASH_SECTORS,
    parameter int EE_SEGMENTS = nvm_access_pkg::EE_SEGMENTS,
    parameter int unsigned PROG_CYCLES = nvm_access_pkg::PROG_CYCLES,
    parameter int unsigned ERASE_CYCLES = nvm_access_pkg::ERASE_CYCLES
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic cmd_valid,
    input wire nvm_access_pkg::op_type cmd_op,
    input wire logic [nvm_access_pkg::ADDR_W-1:0] cmd_addr,
    input wire logic [nvm_access_pkg::LEN_W-1:0] cmd_len,
    input wire logic flash_error_irq_setup,
    input wire nvm_access_pkg::ext_kind_type ext_flash_kind,
    input wire logic wr_valid,
    input wire logic [7:0] wr_data,
    output logic wr_ready,
    output logic rd_valid,
    output logic [7:0] rd_data,
    output logic busy,
    output logic done,
    output nvm_access_pkg::status_type status,
    output logic flash_error_irq,
    output logic ext_flash_power_down,
    output logic [15:0] ee_seg_count,
    output logic [7:0] ee_seg_bytes
);
    import nvm_access_pkg::*;

    localparam int FLASH_BYTES = FLASH_SECTORS * SECTOR_BYTES;
    localparam int FL_AW = $clog2(FLASH_BYTES);
    localparam int SEC_AW = $clog2(SECTOR_BYTES);
    localparam int PW_AW = $clog2(PAGEWORD_BYTES);
    localparam int EE_AW = $clog2(EE_SEGMENTS * EE_SEG_BYTES);
    localparam int SEG_AW = $clog2(EE_SEG_BYTES);

    typedef enum logic [1:0] {S_IDLE, S_XFER, S_CLEAR, S_WAIT} state_type;

    state_type state_r;
    op_type op_r;
    logic [ADDR_W-1:0] ptr_r;
    logic [LEN_W-1:0] left_r;
    logic [31:0] cnt_r;
    logic [31:0] wait_r;
    logic err_seen_r;
    logic wr_ready_r;
    logic rd_valid_r;
    logic [7:0] rd_data_r;
    logic busy_r;
    logic done_r;
    status_type status_r;
    logic flash_err_irq_r;
    logic ext_pd_r;
    logic [15:0] ee_seg_count_r;
    logic [7:0] ee_seg_bytes_r;

    logic [7:0] flash_mem [FLASH_BYTES];
    logic corrupt_mem [FLASH_BYTES / PAGEWORD_BYTES];
    logic [7:0] ee_mem [EE_SEGMENTS * EE_SEG_BYTES];

    logic accept;
    logic wr_take;
    logic is_write;
    logic is_read;
    status_type chk_status;
    logic [ADDR_W:0] end_addr;
    logic [LEN_W:0] sec_end;
    logic [LEN_W:0] ee_end;
    logic [ADDR_W-1:0] seg_idx;

    assign accept = cmd_valid && (state_r == S_IDLE);
    assign wr_take = wr_valid && wr_ready_r;
    assign is_write = (op_r == OP_FLASH_PROGRAM) || (op_r == OP_EE_WRITE);
    assign is_read = (op_r == OP_FLASH_READ) || (op_r == OP_EE_READ);

    // request checks, evaluated before anything is touched
    always_comb begin
        end_addr = {1'b0, cmd_addr} + (ADDR_W+1)'(cmd_len);
        sec_end = (LEN_W+1)'(cmd_addr[SEC_AW-1:0]) + (LEN_W+1)'(cmd_len);
        ee_end = (LEN_W+1)'(cmd_addr[SEG_AW-1:0]) + (LEN_W+1)'(cmd_len);
        seg_idx = cmd_addr >> SEG_AW;
        chk_status = ST_OK;
        case (cmd_op)
            OP_FLASH_READ: begin
                if (end_addr > (ADDR_W+1)'(FLASH_BYTES)) begin
                    chk_status = ST_RANGE;
                end
            end
            OP_FLASH_PROGRAM: begin
                if (cmd_addr[PW_AW-1:0] != '0 || cmd_len[PW_AW-1:0] != '0) begin
                    chk_status = ST_ALIGN;
                end else if (sec_end > (LEN_W+1)'(SECTOR_BYTES) ||
                             end_addr > (ADDR_W+1)'(FLASH_BYTES)) begin
                    chk_status = ST_RANGE;
                end
            end
            OP_FLASH_ERASE: begin
                if (cmd_addr >= ADDR_W'(FLASH_BYTES)) begin
                    chk_status = ST_RANGE;
                end
            end
            OP_EE_WRITE, OP_EE_READ, OP_EE_ERASE: begin
                if (seg_idx >= ADDR_W'(EE_SEGMENTS)) begin
                    chk_status = ST_RANGE;
                end else if (cmd_op != OP_EE_READ && seg_idx == ADDR_W'(EE_SEGMENTS - 1)) begin
                    chk_status = ST_PROTECTED;
                end else if (cmd_op != OP_EE_ERASE && ee_end > (LEN_W+1)'(EE_SEG_BYTES)) begin
                    chk_status = ST_OVERRUN;
                end
            end
            default: begin
                chk_status = ST_OK;
            end
        endcase
    end

    // sequencer
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_r <= S_IDLE;
            op_r <= OP_FLASH_READ;
            ptr_r <= '0;
            left_r <= '0;
            wait_r <= '0;
            err_seen_r <= 1'b0;
            wr_ready_r <= 1'b0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
            status_r <= ST_OK;
            flash_err_irq_r <= 1'b0;
        end else begin
            done_r <= 1'b0;
            flash_err_irq_r <= 1'b0;
            case (state_r)
                S_IDLE: begin
                    if (accept) begin
                        op_r <= cmd_op;
                        err_seen_r <= 1'b0;
                        if (chk_status != ST_OK) begin
                            // refused: nothing written or read
                            done_r <= 1'b1;
                            status_r <= chk_status;
                        end else begin
                            case (cmd_op)
                                OP_FLASH_ERASE: begin
                                    ptr_r <= {cmd_addr[ADDR_W-1:SEC_AW], SEC_AW'(0)};
                                    left_r <= LEN_W'(SECTOR_BYTES);
                                    wait_r <= 32'(ERASE_CYCLES);
                                    state_r <= S_CLEAR;
                                    busy_r <= 1'b1;
                                end
                                OP_EE_ERASE: begin
                                    ptr_r <= {cmd_addr[ADDR_W-1:SEG_AW], SEG_AW'(0)};
                                    left_r <= LEN_W'(EE_SEG_BYTES);
                                    wait_r <= '0;
                                    state_r <= S_CLEAR;
                                    busy_r <= 1'b1;
                                end
                                OP_FLASH_READ, OP_FLASH_PROGRAM, OP_EE_WRITE, OP_EE_READ: begin
                                    ptr_r <= cmd_addr;
                                    left_r <= cmd_len;
                                    wait_r <= (cmd_op == OP_FLASH_PROGRAM) ? 32'(PROG_CYCLES) : 32'h0;
                                    state_r <= (cmd_len == '0) ? S_WAIT : S_XFER;
                                    wr_ready_r <= (cmd_len != '0) &&
                                                  (cmd_op == OP_FLASH_PROGRAM || cmd_op == OP_EE_WRITE);
                                    busy_r <= 1'b1;
                                end
                                default: begin
                                    // power and init commands finish at once
                                    done_r <= 1'b1;
                                    status_r <= ST_OK;
                                end
                            endcase
                        end
                    end
                end
                S_XFER: begin
                    if (is_write) begin
                        if (wr_take) begin
                            ptr_r <= ptr_r + ADDR_W'(1);
                            left_r <= left_r - LEN_W'(1);
                            if (left_r == LEN_W'(1)) begin
                                wr_ready_r <= 1'b0;
                                state_r <= S_WAIT;
                            end
                        end
                    end else begin
                        if (op_r == OP_FLASH_READ && corrupt_mem[ptr_r[FL_AW-1:PW_AW]]) begin
                            err_seen_r <= 1'b1;
                        end
                        ptr_r <= ptr_r + ADDR_W'(1);
                        left_r <= left_r - LEN_W'(1);
                        if (left_r == LEN_W'(1)) begin
                            state_r <= S_WAIT;
                        end
                    end
                end
                S_CLEAR: begin
                    ptr_r <= ptr_r + ADDR_W'(1);
                    left_r <= left_r - LEN_W'(1);
                    if (left_r == LEN_W'(1)) begin
                        state_r <= S_WAIT;
                    end
                end
                S_WAIT: begin
                    if (cnt_r >= wait_r) begin
                        state_r <= S_IDLE;
                        busy_r <= 1'b0;
                        done_r <= 1'b1;
                        status_r <= err_seen_r ? ST_READ_ERROR : ST_OK;
                        flash_err_irq_r <= err_seen_r && flash_error_irq_setup;
                    end
                end
                default: begin
                    state_r <= S_IDLE;
                end
            endcase
        end
    end

    // elapsed time since the command was taken
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cnt_r <= '0;
        end else if (accept) begin
            cnt_r <= 32'h1;
        end else if (busy_r && cnt_r != 32'hFFFFFFFF) begin
            cnt_r <= cnt_r + 32'h1;
        end
    end

    // array updates; no reset so the arrays map onto plain memory
    always_ff @(posedge clock) begin
        if (state_r == S_XFER && wr_take) begin
            if (op_r == OP_FLASH_PROGRAM) begin
                flash_mem[ptr_r[FL_AW-1:0]] <= flash_mem[ptr_r[FL_AW-1:0]] & wr_data;
                // reprogramming a used pageword damages its check bits
                if (flash_mem[ptr_r[FL_AW-1:0]] != FLASH_BLANK) begin
                    corrupt_mem[ptr_r[FL_AW-1:PW_AW]] <= 1'b1;
                end
            end else begin
                ee_mem[ptr_r[EE_AW-1:0]] <= ee_mem[ptr_r[EE_AW-1:0]] | wr_data;
            end
        end
        if (state_r == S_CLEAR) begin
            if (op_r == OP_FLASH_ERASE) begin
                flash_mem[ptr_r[FL_AW-1:0]] <= FLASH_BLANK;
                corrupt_mem[ptr_r[FL_AW-1:PW_AW]] <= 1'b0;
            end else begin
                ee_mem[ptr_r[EE_AW-1:0]] <= EE_BLANK;
            end
        end
    end

    // read data, one byte per cycle, no back-pressure
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rd_valid_r <= 1'b0;
            rd_data_r <= 8'h00;
        end else begin
            rd_valid_r <= (state_r == S_XFER) && is_read;
            if (state_r == S_XFER && is_read) begin
                rd_data_r <= (op_r == OP_FLASH_READ) ? flash_mem[ptr_r[FL_AW-1:0]] : ee_mem[ptr_r[EE_AW-1:0]];
            end
        end
    end

    // external flash power: internal or unknown parts are left alone
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ext_pd_r <= 1'b0;
        end else if (accept && ext_flash_kind == EXT_POWER_CTL) begin
            if (cmd_op == OP_EXT_POWER_OFF) begin
                ext_pd_r <= 1'b1;
            end else if (cmd_op == OP_EXT_POWER_ON) begin
                ext_pd_r <= 1'b0;
            end
        end
    end

    // geometry report
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ee_seg_count_r <= 16'h0000;
            ee_seg_bytes_r <= 8'h00;
        end else if (accept && cmd_op == OP_EE_INIT) begin
            ee_seg_count_r <= 16'(EE_SEGMENTS);
            ee_seg_bytes_r <= 8'(EE_SEG_BYTES);
        end
    end

    assign wr_ready = wr_ready_r;
    assign rd_valid = rd_valid_r;
    assign rd_data = rd_data_r;
    assign busy = busy_r;
    assign done = done_r;
    assign status = status_r;
    assign flash_error_irq = flash_err_irq_r;
    assign ext_flash_power_down = ext_pd_r;
    assign ee_seg_count = ee_seg_count_r;
    assign ee_seg_bytes = ee_seg_bytes_r;

endmodule

// >>> bench/flash_eeprom_access_control_properties.sv
// Purpose: port timing relations of the access block
// Assumes: one clock, nrst async active low
// Notes: run_cnt counts busy cycles so long waits need no repetition
`timescale 1ns/1ps
module flash_eeprom_access_control_properties
    import nvm_access_pkg::*;
#(
    parameter int FLASH_SECTORS = 8,
    parameter int EE_SEGMENTS = 64,
    parameter int unsigned PROG_CYCLES = 20,
    parameter int unsigned ERASE_CYCLES = 40
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic cmd_valid,
    input wire nvm_access_pkg::op_type cmd_op,
    input wire logic [nvm_access_pkg::ADDR_W-1:0] cmd_addr,
    input wire logic [nvm_access_pkg::LEN_W-1:0] cmd_len,
    input wire logic flash_error_irq_setup,
    input wire nvm_access_pkg::ext_kind_type ext_flash_kind,
    input wire logic wr_valid,
    input wire logic [7:0] wr_data,
    input wire logic wr_ready,
    input wire logic rd_valid,
    input wire logic [7:0] rd_data,
    input wire logic busy,
    input wire logic done,
    input wire nvm_access_pkg::status_type status,
    input wire logic flash_error_irq,
    input wire logic ext_flash_power_down,
    input wire logic [15:0] ee_seg_count,
    input wire logic [7:0] ee_seg_bytes
);
    logic [31:0] run_cnt;
    op_type op_r;
    // op is held by the requester until done, so latching while idle is enough
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            run_cnt <= '0;
            op_r <= OP_FLASH_READ;
        end else begin
            run_cnt <= busy ? run_cnt + 32'h1 : '0;
            op_r <= busy ? op_r : cmd_op;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    a_busy_ends_done: assert property ($fell(busy) |-> done) else $error("busy fell without done");
    a_done_one_pulse: assert property (done |=> !done) else $error("done longer than one cycle");
    a_status_holds: assert property (!done |-> $stable(status)) else $error("status moved without done");
    a_refusal_idle: assert property (done && status inside {ST_ALIGN, ST_RANGE, ST_OVERRUN, ST_PROTECTED}
        |-> !$past(busy)) else $error("refused command ran");
    a_prog_waits: assert property ($fell(busy) && op_r == OP_FLASH_PROGRAM |-> run_cnt >= PROG_CYCLES - 1)
        else $error("program finished early");
    a_erase_whole: assert property ($fell(busy) && op_r == OP_FLASH_ERASE |-> run_cnt >= SECTOR_BYTES - 1)
        else $error("sector erase too short");
    a_ee_erase_span: assert property ($fell(busy) && op_r == OP_EE_ERASE |-> run_cnt >= EE_SEG_BYTES - 1)
        else $error("segment erase too short");
    a_irq_on_error: assert property (flash_error_irq |-> done && status == ST_READ_ERROR
        && op_r == OP_FLASH_READ) else $error("stray error interrupt");
    a_irq_when_enabled: assert property (done && status == ST_READ_ERROR && $past(flash_error_irq_setup)
        |-> flash_error_irq) else $error("error interrupt missing");
    a_power_kind: assert property ($changed(ext_flash_power_down) |-> done
        && $past(ext_flash_kind) == EXT_POWER_CTL) else $error("power state changed for wrong kind");
    a_init_report: assert property (done && op_r == OP_EE_INIT |-> ee_seg_count == EE_SEGMENTS
        && ee_seg_bytes == 8'h40) else $error("init report wrong");
    c_overrun: cover property (done && status == ST_OVERRUN);
    c_irq: cover property (flash_error_irq);
    c_power_off: cover property ($rose(ext_flash_power_down));
endmodule

bind flash_eeprom_access_control flash_eeprom_access_control_properties #(.FLASH_SECTORS(FLASH_SECTORS),
    .EE_SEGMENTS(EE_SEGMENTS), .PROG_CYCLES(PROG_CYCLES), .ERASE_CYCLES(ERASE_CYCLES)) props (
    .clock(clock), .nrst(nrst), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_len(cmd_len),
    .flash_error_irq_setup(flash_error_irq_setup), .ext_flash_kind(ext_flash_kind), .wr_valid(wr_valid),
    .wr_data(wr_data), .wr_ready(wr_ready), .rd_valid(rd_valid), .rd_data(rd_data), .busy(busy), .done(done),
    .status(status), .flash_error_irq(flash_error_irq), .ext_flash_power_down(ext_flash_power_down),
    .ee_seg_count(ee_seg_count), .ee_seg_bytes(ee_seg_bytes));

// >>> bench/ext_flash_model.sv
// Purpose: external serial flash power state seen from the far side
// Assumes: power_down is a level from the access block
// Notes: counts accesses made while unpowered
`timescale 1ns/1ps
module ext_flash_model (
    input wire logic clock,
    input wire logic nrst,
    input wire logic power_down,
    input wire logic access,
    output logic powered,
    output logic [7:0] bad_access
);
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            powered <= 1'b1;
            bad_access <= 8'h00;
        end else begin
            powered <= !power_down;
            bad_access <= bad_access + 8'((access && !powered) ? 1 : 0);
        end
    end
endmodule

// >>> bench/flash_eeprom_access_control_bench.sv
// Purpose: self-checking bench for the flash and eeprom access block
// Assumes: inputs change and outputs are read on the falling edge
// Notes: short counts; only sector 0 is erased to keep the run small
`timescale 1ns/1ps
module flash_eeprom_access_control_bench;
    import nvm_access_pkg::*;
    logic clock, nrst, cmd_valid, flash_error_irq_setup, wr_valid, wr_ready, rd_valid, busy, done;
    logic flash_error_irq, ext_flash_power_down, powered, irq_seen;
    op_type cmd_op;
    logic [ADDR_W-1:0] cmd_addr;
    logic [LEN_W-1:0] cmd_len;
    ext_kind_type ext_flash_kind;
    logic [7:0] wr_data, rd_data, ee_seg_bytes, bad_access;
    status_type status, st;
    logic [15:0] ee_seg_count;
    int num_errors, compares;
    logic [7:0] wq[$], rq[$], eq[$];

    flash_eeprom_access_control #(.FLASH_SECTORS(2), .EE_SEGMENTS(4), .PROG_CYCLES(20), .ERASE_CYCLES(40)) DUT (
        .clock(clock), .nrst(nrst), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_len(cmd_len),
        .flash_error_irq_setup(flash_error_irq_setup), .ext_flash_kind(ext_flash_kind), .wr_valid(wr_valid),
        .wr_data(wr_data), .wr_ready(wr_ready), .rd_valid(rd_valid), .rd_data(rd_data), .busy(busy), .done(done),
        .status(status), .flash_error_irq(flash_error_irq), .ext_flash_power_down(ext_flash_power_down),
        .ee_seg_count(ee_seg_count), .ee_seg_bytes(ee_seg_bytes));
    ext_flash_model partner (.clock(clock), .nrst(nrst), .power_down(ext_flash_power_down),
        .access(cmd_valid && cmd_op == OP_FLASH_READ), .powered(powered), .bad_access(bad_access));

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one command, write bytes from wq, read bytes into rq, status into st
    task automatic run(input op_type op, input int addr, input int len);
        int idx;
        logic take;
        idx = 0;
        take = 1'b0;
        rq = {};
        @(negedge clock);
        cmd_op = op;
        cmd_addr = addr[ADDR_W-1:0];
        cmd_len = len[LEN_W-1:0];
        cmd_valid = 1'b1;
        @(negedge clock);
        cmd_valid = 1'b0;
        for (int n = 0; n < 40000; n++) begin
            if (rd_valid) rq.push_back(rd_data);
            if (done) break;
            if (take) idx++;
            wr_valid = idx < wq.size();
            wr_data = wr_valid ? wq[idx] : 8'h00;
            take = wr_ready && wr_valid;
            @(negedge clock);
        end
        check("done", {15'h0000, done}, 16'h0001);
        irq_seen = flash_error_irq;
        st = status;
        wr_valid = 1'b0;
    endtask

    task automatic cmp_rd();
        check("read count", 16'(rq.size()), 16'(eq.size()));
        foreach (eq[i]) check("read byte", {8'h00, rq[i]}, {8'h00, eq[i]});
    endtask

    task automatic t_init();
        run(OP_EE_INIT, 0, 0);
        check("seg count", ee_seg_count, 16'h0004);
        check("seg bytes", {8'h00, ee_seg_bytes}, 16'h0040);
    endtask

    task automatic t_eeprom();
        wq = {};
        run(OP_EE_ERASE, 'h80, 0);
        run(OP_EE_ERASE, 'h40, 0);
        run(OP_EE_READ, 'h7C, 4);
        eq = {8'h00, 8'h00, 8'h00, 8'h00};
        cmp_rd();
        wq = {8'hA5, 8'h0F, 8'h30, 8'h01};
        run(OP_EE_WRITE, 'h7C, 4);
        wq = {8'h5A, 8'h30, 8'h03, 8'h80};
        run(OP_EE_WRITE, 'h7C, 4);
        wq = {8'hFF, 8'hFF, 8'hFF};
        run(OP_EE_WRITE, 'h7E, 3);
        check("overrun write", 16'(st), 16'(ST_OVERRUN));
        wq = {};
        run(OP_EE_READ, 'h7E, 3);
        check("overrun read", 16'(st), 16'(ST_OVERRUN));
        check("overrun bytes", 16'(rq.size()), 16'h0000);
        run(OP_EE_READ, 'h7C, 4);
        eq = {8'hFF, 8'h3F, 8'h33, 8'h81};
        cmp_rd();
        wq = {8'h11};
        run(OP_EE_WRITE, 'hC0, 1);
        check("last seg write", 16'(st), 16'(ST_PROTECTED));
        run(OP_EE_ERASE, 'hC0, 0);
        check("last seg erase", 16'(st), 16'(ST_PROTECTED));
        wq = {8'h21};
        run(OP_EE_WRITE, 'h80, 1);
        wq = {};
        run(OP_EE_ERASE, 'h40, 0);
        run(OP_EE_READ, 'h7C, 1);
        eq = {8'h00};
        cmp_rd();
        run(OP_EE_READ, 'h80, 1);
        eq = {8'h21};
        cmp_rd();
    endtask

    task automatic t_flash();
        run(OP_FLASH_ERASE, 'h10000, 0);
        check("absent sector", 16'(st), 16'(ST_RANGE));
        run(OP_FLASH_ERASE, 0, 0);
        run(OP_FLASH_READ, 'h7FFE, 2);
        eq = {8'hFF, 8'hFF};
        cmp_rd();
        eq = {};
        for (int i = 0; i < 16; i++) wq.push_back(8'(i * 17));
        run(OP_FLASH_PROGRAM, 'h10, 16);
        run(OP_FLASH_PROGRAM, 'h18, 16);
        check("odd start", 16'(st), 16'(ST_ALIGN));
        run(OP_FLASH_PROGRAM, 'h20, 8);
        check("odd length", 16'(st), 16'(ST_ALIGN));
        run(OP_FLASH_PROGRAM, 'h7FF0, 32);
        check("sector cross", 16'(st), 16'(ST_RANGE));
        foreach (wq[i]) eq.push_back(wq[i] & 8'h0F);
        wq = {};
        for (int i = 0; i < 16; i++) wq.push_back(8'h0F);
        run(OP_FLASH_PROGRAM, 'h10, 16);
        wq = {};
        flash_error_irq_setup = 1'b1;
        run(OP_FLASH_READ, 'h10, 16);
        cmp_rd();
        check("read error", 16'(st), 16'(ST_READ_ERROR));
        check("error irq", {15'h0000, irq_seen}, 16'h0001);
    endtask

    // read, merge, erase, program back; only the first 32 bytes of sector 0 hold data
    task automatic t_merge();
        wq = {};
        run(OP_FLASH_READ, 'h00, 32);
        eq = rq;
        eq[3] = 8'hC3;
        run(OP_FLASH_ERASE, 0, 0);
        wq = eq;
        run(OP_FLASH_PROGRAM, 'h00, 32);
        check("merge program", 16'(st), 16'(ST_OK));
        wq = {};
        run(OP_FLASH_READ, 'h00, 32);
        cmp_rd();
        check("merge read", 16'(st), 16'(ST_OK));
        check("merge irq", {15'h0000, irq_seen}, 16'h0000);
    endtask

    task automatic t_power();
        for (int k = 0; k < 4; k++) begin
            ext_flash_kind = ext_kind_type'(k);
            run(OP_EXT_POWER_OFF, 0, 0);
            check("powered down", {15'h0000, ext_flash_power_down}, 16'(k == 1));
            repeat (20) @(negedge clock);
            check("model power", {15'h0000, powered}, 16'(k != 1));
            run(OP_EXT_POWER_ON, 0, 0);
            check("powered up", {15'h0000, ext_flash_power_down}, 16'h0000);
        end
        ext_flash_kind = EXT_POWER_CTL;
        run(OP_FLASH_READ, 'h10, 1);
        check("unpowered access", {8'h00, bad_access}, 16'h0000);
    endtask

    task automatic results();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        nrst = 1'b0;
        cmd_valid = 1'b0;
        cmd_op = OP_FLASH_READ;
        cmd_addr = '0;
        cmd_len = '0;
        flash_error_irq_setup = 1'b0;
        ext_flash_kind = EXT_INTERNAL;
        wr_valid = 1'b0;
        wr_data = 8'h00;
        num_errors = 0;
        compares = 0;
        repeat (12) @(negedge clock);
        nrst = 1'b1;
        t_init();
        t_eeprom();
        t_flash();
        t_merge();
        t_power();
        results();
    end

    // whole run is near 66k cycles, dominated by two sector erases
    initial begin
        #400000;
        num_errors++;
        results();
    end
endmodule
